// ===== logic/iqclk_pkg.sv
// Package for the I/Q interface clock planner: register map, field codes, limits.
// Assumes an APB slave with 32-bit data; rates are held in kHz.
package iqclk_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CLK_RATE = 8'h04;
	localparam logic [7:0] OFF_SAMPLE_RATE = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_LIMITS_MIN = 8'h10;
	localparam logic [7:0] OFF_LIMITS_MAX = 8'h14;
	// Control field positions
	localparam int CTRL_PORT_LSB = 0;
	localparam int CTRL_LVDS_BIT = 2;
	localparam int CTRL_IF_BIT = 3;
	localparam int CTRL_INPUT_BIT = 4;
	localparam int CTRL_UNFILT_BIT = 5;
	localparam int CTRL_CPS_LSB = 6;
	localparam int CTRL_SRC_LSB = 8;
	localparam int CTRL_QFIRST_BIT = 10;
	localparam int CTRL_WORD_LSB = 16;
	// Port modes
	localparam logic [1:0] PORT_PARALLEL = 2'h0;
	localparam logic [1:0] PORT_SERIAL = 2'h1;
	localparam logic [1:0] PORT_INTERLEAVED = 2'h2;
	// Clock sources
	localparam logic [1:0] SRC_INTERNAL = 2'h0;
	localparam logic [1:0] SRC_EXTERNAL = 2'h1;
	localparam logic [1:0] SRC_DEVICE = 2'h2;
	// Rate limits in kHz
	localparam logic [31:0] RATE_MIN_KHZ = 32'h0000_0001;
	localparam logic [31:0] CLK_ABS_MAX_KHZ = 32'h0006_1a80;
	localparam logic [31:0] SMP_ABS_MAX_KHZ = 32'h0003_0d40;
	localparam logic [31:0] SE_MAX_KHZ = 32'h0002_49f0;
	localparam logic [31:0] LVDS_MAX_KHZ = 32'h0006_1a80;
	localparam logic [31:0] PAR_PER_CPS_KHZ = 32'h0001_86a0;
	localparam logic [31:0] IN_FILT_MAX_KHZ = 32'h0003_0d40;
	localparam logic [31:0] IN_UNFILT_MAX_KHZ = 32'h0001_86a0;
	localparam logic [31:0] SER_UNFILT_PER_BIT_KHZ = 32'h0000_c350;
	localparam logic [31:0] IF_MIN_KHZ = 32'h0000_0004;
	// Reset values
	localparam logic [31:0] CTRL_RESET = 32'h0010_0040;
	localparam logic [31:0] CLK_RATE_RESET = 32'h0000_2710;
	localparam logic [5:0] WORD_RESET = 6'h10;
endpackage : iqclk_pkg

// ===== logic/iq_interface_clock_rates.sv
// I/Q interface clock planner: range checks, sample rate, output clock and framing.
// Assumes an APB master on ref_clk; the three clock sources arrive as sampled levels.
// Function
// (RULE1) Clock rate accepted only within 1 kHz to 400 MHz, narrowed per mode.
// (RULE2) Sample rate derived from clock settings, kept within 1 kHz to 200 MHz.
// (RULE3) Sample rate equals clock rate unless serial or several clocks per sample.
// (RULE4) Interface clock marks when a sample of word-size bits is stable.
// (RULE5) Serial clock at most 150 MHz single-ended, 400 MHz LVDS, least 1 kHz per bit.
// (RULE6) Serial sample rate least 1 kHz, most clock maximum over word size.
// (RULE7) With several clocks per sample, sample rate is clock rate over that count.
// (RULE8) Clocks per sample forced to one for IF signal or input mode.
// (RULE9) Parallel output clock from 1 kHz*cps to min(100 MHz*cps, logic maximum).
// (RULE10) Parallel input clock 1 kHz to 200 MHz filtered, 100 MHz unfiltered.
// (RULE11) Serial LVDS unfiltered input clock capped at min(50 MHz*word, 400 MHz).
// (RULE12) Interface clock taken from internal, external or device connector source.
// (RULE13) Software sets clock rate to the applied clock frequency for outside sources.
// (RULE14) Internal source needs a frequency reference supplied and its setting matched.
// (RULE15) Selected source drives both clock output and device connector clock.
// (RULE16) Parallel output allows 1, 2 or 4 clocks per sample, holding data.
// (RULE17) Interleaved mode carries I and Q on the I lines, order selectable.
// (RULE18) Serial mode gives one clock per bit and a frame pulse on the first bit.
// (RULE19) Out-of-range clock rate, word size or cps settings are rejected.
// (RULE20) Derived rate and allowed range recomputed whenever settings change.
`timescale 1ns/1ps
module iq_interface_clock_rates #(
	parameter int WORD_MAX = 32
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic int_synth_clk,
	input wire logic ext_clk_in,
	input wire logic dut_clk_in,
	input wire logic [WORD_MAX-1:0] i_word,
	input wire logic [WORD_MAX-1:0] q_word,
	output logic sample_take,
	output logic clk_out,
	output logic dut_clk_out,
	output logic [WORD_MAX-1:0] i_lines,
	output logic [WORD_MAX-1:0] q_lines,
	output logic serial_bit,
	output logic frame_pulse
);
	typedef enum logic [1:0] {
		PH_FIRST = 2'b00,
		PH_SECOND = 2'b01,
		PH_THIRD = 2'b11,
		PH_FOURTH = 2'b10
	} phase_t;

	logic [31:0] ctrl_q;
	logic [31:0] clk_rate_q;
	logic [31:0] sample_rate_q;
	logic [31:0] min_q;
	logic [31:0] max_q;
	logic reject_q;
	logic [31:0] cand_ctrl;
	logic [31:0] cand_rate;
	logic cand_ok;
	logic [31:0] cand_min;
	logic [31:0] cand_max;
	logic [31:0] cand_smp;
	logic [31:0] cur_min;
	logic [31:0] cur_max;
	logic [31:0] cur_smp;
	logic cur_ok;
	logic wr_en;
	logic rd_en;
	logic src_clk;
	logic src_prev_q;
	logic src_rise;
	// Source edges and the interleave half of the current clock
	logic src_fall;
	logic first_half;
	phase_t phase_q;
	logic [5:0] bit_cnt_q;
	logic [WORD_MAX-1:0] i_hold_q;
	logic [WORD_MAX-1:0] q_hold_q;
	logic [WORD_MAX-1:0] shift_q;

	localparam int CTRL_SEL_CPS = iqclk_pkg::CTRL_CPS_LSB;

	// Effective clocks per sample: 1, 2 or 4; IF or input forces one
	function automatic logic [2:0] eff_cps(input logic [31:0] c);
		logic [1:0] code;
		code = c[CTRL_SEL_CPS +: 2];
		if (c[iqclk_pkg::CTRL_IF_BIT] || c[iqclk_pkg::CTRL_INPUT_BIT]) begin
			return 3'h1; // RULE8
		end
		// Code 3 never commits, since the legality check refuses it
		case (code)
			2'h1: return 3'h2;
			2'h2: return 3'h4;
			default: return 3'h1;
		endcase
	endfunction : eff_cps

	// Smaller of two rates; most ceilings are the lesser of two limits
	function automatic logic [31:0] lesser(input logic [31:0] a, input logic [31:0] b);
		return (a < b) ? a : b;
	endfunction : lesser

	// Range and sample rate for one candidate setting; shared by write check and readback
	function automatic logic [95:0] plan(input logic [31:0] c, input logic [31:0] rate);
		logic [1:0] port;
		logic [31:0] word;
		logic [31:0] cps;
		logic [31:0] lmax;
		logic [31:0] mn;
		logic [31:0] mx;
		logic [31:0] smp;
		port = c[iqclk_pkg::CTRL_PORT_LSB +: 2];
		word = {26'h000_0000, c[iqclk_pkg::CTRL_WORD_LSB +: 6]};
		cps = {29'h0000_0000, eff_cps(c)};
		lmax = c[iqclk_pkg::CTRL_LVDS_BIT] ? iqclk_pkg::LVDS_MAX_KHZ : iqclk_pkg::SE_MAX_KHZ;
		mn = iqclk_pkg::RATE_MIN_KHZ;
		mx = iqclk_pkg::CLK_ABS_MAX_KHZ; // RULE1
		smp = rate; // RULE3
		if (port == iqclk_pkg::PORT_SERIAL) begin
			mn = iqclk_pkg::RATE_MIN_KHZ * word; // RULE5
			mx = lmax; // RULE5
			if (c[iqclk_pkg::CTRL_INPUT_BIT] && c[iqclk_pkg::CTRL_LVDS_BIT]
					&& c[iqclk_pkg::CTRL_UNFILT_BIT]) begin
				mx = lesser(iqclk_pkg::SER_UNFILT_PER_BIT_KHZ * word, lmax); // RULE11
			end
			smp = (word != 32'h0000_0000) ? rate / word : 32'h0000_0000; // RULE6
		end else if (c[iqclk_pkg::CTRL_INPUT_BIT]) begin
			mx = c[iqclk_pkg::CTRL_UNFILT_BIT] ? iqclk_pkg::IN_UNFILT_MAX_KHZ
				: iqclk_pkg::IN_FILT_MAX_KHZ; // RULE10
		end else if (c[iqclk_pkg::CTRL_IF_BIT]) begin
			// IF has a fixed floor and only the logic ceiling
			mn = iqclk_pkg::IF_MIN_KHZ;
			mx = lmax;
		end else begin
			mn = iqclk_pkg::RATE_MIN_KHZ * cps; // RULE9
			mx = lesser(iqclk_pkg::PAR_PER_CPS_KHZ * cps, lmax); // RULE9
			smp = rate / cps; // RULE7
		end
		mx = lesser(mx, iqclk_pkg::CLK_ABS_MAX_KHZ); // RULE1
		return {mn, mx, smp};
	endfunction : plan

	// Legal settings: known port and source, cps code 0..2, word 1..WORD_MAX
	function automatic logic legal(input logic [31:0] c, input logic [31:0] rate);
		logic [95:0] p;
		logic [31:0] word;
		p = plan(c, rate);
		word = {26'h000_0000, c[iqclk_pkg::CTRL_WORD_LSB +: 6]};
		return (c[iqclk_pkg::CTRL_PORT_LSB +: 2] != 2'h3)
			&& (c[iqclk_pkg::CTRL_SRC_LSB +: 2] != 2'h3)
			&& (c[CTRL_SEL_CPS +: 2] != 2'h3)
			&& (word != 32'h0000_0000) && (word <= WORD_MAX)
			&& (rate >= p[95:64]) && (rate <= p[63:32])
			&& (p[31:0] >= iqclk_pkg::RATE_MIN_KHZ)
			&& (p[31:0] <= iqclk_pkg::SMP_ABS_MAX_KHZ); // RULE19 RULE2
	endfunction : legal

	// Writes land in the access phase; read data is latched at setup
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	// Candidate setting formed from the pending write
	always_comb begin
		cand_ctrl = ctrl_q;
		cand_rate = clk_rate_q;
		if (wr_en && paddr == iqclk_pkg::OFF_CTRL) begin
			cand_ctrl = pwdata;
		end
		if (wr_en && paddr == iqclk_pkg::OFF_CLK_RATE) begin
			cand_rate = pwdata; // RULE13
		end
		cand_ok = legal(cand_ctrl, cand_rate);
		{cand_min, cand_max, cand_smp} = plan(cand_ctrl, cand_rate);
		// Readback copy from the settings that stand now
		{cur_min, cur_max, cur_smp} = plan(ctrl_q, clk_rate_q);
		cur_ok = legal(ctrl_q, clk_rate_q);
	end

	// Settings commit only when the whole combination stays legal
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= iqclk_pkg::CTRL_RESET;
			clk_rate_q <= iqclk_pkg::CLK_RATE_RESET;
			reject_q <= 1'b0;
		end else if (wr_en && (paddr == iqclk_pkg::OFF_CTRL || paddr == iqclk_pkg::OFF_CLK_RATE)) begin
			if (cand_ok) begin
				ctrl_q <= cand_ctrl; // RULE19
				clk_rate_q <= cand_rate;
			end
			reject_q <= !cand_ok; // RULE19
		end
	end

	// Derived values registered every cycle so any change is reflected next cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_rate_q <= 32'h0000_0000;
			min_q <= 32'h0000_0000;
			max_q <= 32'h0000_0000;
		end else begin
			sample_rate_q <= cur_smp; // RULE20 RULE2
			min_q <= cur_min; // RULE20
			max_q <= cur_max; // RULE20
		end
	end

	// APB slave: zero wait states, error on unmapped or refused write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (rd_en) begin
				case (paddr)
					iqclk_pkg::OFF_CTRL: prdata <= ctrl_q;
					iqclk_pkg::OFF_CLK_RATE: prdata <= clk_rate_q;
					iqclk_pkg::OFF_SAMPLE_RATE: prdata <= sample_rate_q;
					iqclk_pkg::OFF_STATUS: prdata <= {29'h0000_0000, eff_cps(ctrl_q) == 3'h1,
						cur_ok, reject_q};
					iqclk_pkg::OFF_LIMITS_MIN: prdata <= min_q;
					iqclk_pkg::OFF_LIMITS_MAX: prdata <= max_q;
					default: begin
						prdata <= 32'h0000_0000;
						pslverr <= 1'b1;
					end
				endcase
			end else if (psel && !penable && pwrite) begin
				// Judged at setup; the same settings still stand at the access edge
				if (paddr == iqclk_pkg::OFF_CTRL || paddr == iqclk_pkg::OFF_CLK_RATE) begin
					pslverr <= !legal((paddr == iqclk_pkg::OFF_CTRL) ? pwdata : ctrl_q,
						(paddr == iqclk_pkg::OFF_CLK_RATE) ? pwdata : clk_rate_q);
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	// Source select; the picked level is sampled on ref_clk
	always_comb begin
		case (ctrl_q[iqclk_pkg::CTRL_SRC_LSB +: 2])
			iqclk_pkg::SRC_EXTERNAL: src_clk = ext_clk_in; // RULE12
			iqclk_pkg::SRC_DEVICE: src_clk = dut_clk_in; // RULE12
			default: src_clk = int_synth_clk; // RULE12 RULE14
		endcase
	end

	// Edges of the picked source; a source switch can show one false edge,
	// since the remembered level still belongs to the old source
	assign src_rise = src_clk && !src_prev_q;
	assign src_fall = !src_clk && src_prev_q;

	// Interleaved words split each sample in halves: two of four clocks, one of two
	assign first_half = (phase_q == PH_FIRST)
		|| (phase_q == PH_SECOND && eff_cps(ctrl_q) == 3'h4); // RULE17

	// Clock outputs follow the source one ref_clk later; outside clocks must be well below ref_clk
	// Limitation: a source near half of ref_clk loses edges, so keep it under a quarter
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_prev_q <= 1'b0;
			clk_out <= 1'b0;
			dut_clk_out <= 1'b0;
		end else begin
			src_prev_q <= src_clk;
			clk_out <= src_clk; // RULE15
			dut_clk_out <= src_clk; // RULE15 RULE4
		end
	end

	// Per-clock framing: phase counts clocks within a sample, bit_cnt counts serial bits
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= PH_FIRST;
			bit_cnt_q <= 6'h00;
			sample_take <= 1'b0;
			frame_pulse <= 1'b0;
			serial_bit <= 1'b0;
			i_hold_q <= '0;
			q_hold_q <= '0;
			shift_q <= '0;
			i_lines <= '0;
			q_lines <= '0;
		end else begin
			sample_take <= 1'b0;
			if (src_rise) begin
				if (ctrl_q[iqclk_pkg::CTRL_PORT_LSB +: 2] == iqclk_pkg::PORT_SERIAL) begin
					// RULE18
					if (bit_cnt_q == 6'h00) begin
						shift_q <= i_word >> 1;
						serial_bit <= i_word[0];
						frame_pulse <= 1'b1; // RULE18
						sample_take <= 1'b1;
					end else begin
						shift_q <= shift_q >> 1;
						serial_bit <= shift_q[0];
						frame_pulse <= 1'b0;
					end
					bit_cnt_q <= (bit_cnt_q + 6'h01 >= ctrl_q[iqclk_pkg::CTRL_WORD_LSB +: 6])
						? 6'h00 : bit_cnt_q + 6'h01;
				end else begin
					frame_pulse <= 1'b0;
					if (phase_q == PH_FIRST) begin
						i_hold_q <= i_word; // RULE16
						q_hold_q <= q_word;
						sample_take <= 1'b1;
					end
					case (phase_q)
						PH_FIRST: phase_q <= (eff_cps(ctrl_q) == 3'h1) ? PH_FIRST : PH_SECOND;
						PH_SECOND: phase_q <= (eff_cps(ctrl_q) == 3'h2) ? PH_FIRST : PH_THIRD;
						PH_THIRD: phase_q <= PH_FOURTH;
						default: phase_q <= PH_FIRST;
					endcase
					if (ctrl_q[iqclk_pkg::CTRL_PORT_LSB +: 2] == iqclk_pkg::PORT_INTERLEAVED) begin
						// RULE17: first half of the sample on I lines, second half the other word
						q_lines <= '0;
						if (first_half == !ctrl_q[iqclk_pkg::CTRL_QFIRST_BIT]) begin
							i_lines <= (phase_q == PH_FIRST) ? i_word : i_hold_q;
						end else begin
							i_lines <= (phase_q == PH_FIRST) ? q_word : q_hold_q;
						end
					end else begin
						i_lines <= (phase_q == PH_FIRST) ? i_word : i_hold_q; // RULE16
						q_lines <= (phase_q == PH_FIRST) ? q_word : q_hold_q; // RULE16
					end
				end
			end else if (src_fall && eff_cps(ctrl_q) == 3'h1
					&& ctrl_q[iqclk_pkg::CTRL_PORT_LSB +: 2] == iqclk_pkg::PORT_INTERLEAVED) begin
				// One clock per sample: the second word rides the falling transition
				i_lines <= ctrl_q[iqclk_pkg::CTRL_QFIRST_BIT] ? i_hold_q : q_hold_q; // RULE17
			end
		end
	end
endmodule : iq_interface_clock_rates

// ===== sim/iq_clk_rates_asserts.sv
// Checker for the I/Q clock planner: bus answers, refusals, clock routing.
// Assumes it is bound to the planner top and sees only its ports.
`timescale 1ns/1ps
module iq_clk_rates_asserts (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic int_synth_clk,
	input wire logic ext_clk_in,
	input wire logic dut_clk_in,
	input wire logic clk_out,
	input wire logic dut_clk_out,
	input wire logic sample_take
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Setup phases sorted by what they ask for
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence bad_rate_s;
		setup_s ##0 (pwrite && paddr == iqclk_pkg::OFF_CLK_RATE &&
			(pwdata < iqclk_pkg::RATE_MIN_KHZ || pwdata > iqclk_pkg::CLK_ABS_MAX_KHZ));
	endsequence
	ready_after_setup_a: assert property (setup_s |=> pready)
		else $error("no bus answer after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("bus answer held two cycles");
	ro_write_err_a: assert property (setup_s ##0 pwrite
		##0 (paddr == iqclk_pkg::OFF_SAMPLE_RATE) |=> pslverr && pready)
		else $error("read-only write not refused");
	unmapped_err_a: assert property (setup_s ##0 (paddr > iqclk_pkg::OFF_LIMITS_MAX)
		|=> pslverr) else $error("unmapped access not refused");
	bad_rate_a: assert property (bad_rate_s |=> pslverr)
		else $error("rate outside absolute range accepted");
	good_read_a: assert property (setup_s ##0 (!pwrite && paddr[1:0] == 2'h0)
		##0 (paddr <= iqclk_pkg::OFF_LIMITS_MAX) |=> !pslverr)
		else $error("mapped read refused");
	route_same_a: assert property (clk_out == dut_clk_out)
		else $error("clock outputs differ");
	src_follow_a: assert property ($rose(clk_out) |-> $past(int_synth_clk)
		|| $past(ext_clk_in) || $past(dut_clk_in)) else $error("clock rose with no source high");
	take_pulse_a: assert property (sample_take |=> !sample_take)
		else $error("sample strobe longer than one cycle");
endmodule : iq_clk_rates_asserts
bind iq_interface_clock_rates iq_clk_rates_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .int_synth_clk(int_synth_clk),
	.ext_clk_in(ext_clk_in), .dut_clk_in(dut_clk_in), .clk_out(clk_out),
	.dut_clk_out(dut_clk_out), .sample_take(sample_take));

// ===== sim/iq_far_end.sv
// Far-end model: device under test with its own clock and sample words.
// Assumes ref_clk is the common reference; clock half period in ref_clk cycles.
`timescale 1ns/1ps
module iq_far_end #(
	parameter int HALF = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sample_take,
	output logic dut_clk_in,
	output logic [31:0] i_word,
	output logic [31:0] q_word
);
	int cnt;
	// Clock derived from the shared reference, so the programmed rate stays exact
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			dut_clk_in <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			dut_clk_in <= ~dut_clk_in;
		end else begin
			cnt <= cnt + 1;
		end
	end
	// Fresh words after each capture so a stale sample would show
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			i_word <= 32'h0000_0001;
			q_word <= 32'hffff_fffe;
		end else if (sample_take) begin
			i_word <= i_word + 32'h0000_0001;
			q_word <= ~(i_word + 32'h0000_0001);
		end
	end
endmodule : iq_far_end

// ===== sim/iq_interface_clock_rates_tb.sv
// Self-checking bench for the I/Q clock planner: registers, rate limits, routing.
// Assumes the package, checker and far-end model are compiled first.
`timescale 1ns/1ps
module iq_interface_clock_rates_tb;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic int_synth_clk = 1'b0;
	logic ext_clk_in = 1'b0;
	logic dut_clk_in;
	logic [31:0] i_word;
	logic [31:0] q_word;
	logic sample_take;
	logic clk_out;
	logic dut_clk_out;
	logic [31:0] i_lines;
	logic [31:0] q_lines;
	logic serial_bit;
	logic frame_pulse;
	logic [31:0] rd_q;
	logic err_q;
	int num_errors = 0;
	int compares = 0;
	int cycles = 0;
	always #5 ref_clk = ~ref_clk;
	iq_interface_clock_rates uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .int_synth_clk(int_synth_clk),
		.ext_clk_in(ext_clk_in), .dut_clk_in(dut_clk_in), .i_word(i_word), .q_word(q_word),
		.sample_take(sample_take), .clk_out(clk_out), .dut_clk_out(dut_clk_out),
		.i_lines(i_lines), .q_lines(q_lines), .serial_bit(serial_bit),
		.frame_pulse(frame_pulse));
	iq_far_end #(.HALF(8)) u_far (.ref_clk(ref_clk), .rst_n(rst_n),
		.sample_take(sample_take), .dut_clk_in(dut_clk_in), .i_word(i_word), .q_word(q_word));
	// Internal 10 MHz and external 5 MHz sources; timeout guard
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles % 5 == 4) int_synth_clk <= ~int_synth_clk;
		if (cycles % 10 == 9) ext_clk_in <= ~ext_clk_in;
		if (cycles == 20000) begin
			num_errors = num_errors + 1;
			test_done();
		end
	end
	task automatic test_done();
		$display("Checks %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// One bus transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1);
		chk("bus wait", 32'(n), 32'h0000_0001);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		chk("write refusal", 32'(err_q), 32'(e));
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk("read value", rd_q & m, e);
	endtask : rd
	task automatic t_reset();
		rd(iqclk_pkg::OFF_CTRL, 32'hffff_ffff, iqclk_pkg::CTRL_RESET);
		rd(iqclk_pkg::OFF_CLK_RATE, 32'hffff_ffff, iqclk_pkg::CLK_RATE_RESET);
		rd(iqclk_pkg::OFF_SAMPLE_RATE, 32'hffff_ffff, 32'h0000_1388);
		wr(iqclk_pkg::OFF_STATUS, 32'h0000_0000, 1'b1);
		wr(8'h18, 32'h0000_0000, 1'b1);
		$display("test reset done");
	endtask : t_reset
	// Parallel output: cps 2 then 4, single-ended then LVDS ceilings
	task automatic t_parallel();
		wr(iqclk_pkg::OFF_CLK_RATE, 32'h0000_0000, 1'b1);
		rd(iqclk_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0001);
		wr(iqclk_pkg::OFF_CLK_RATE, 32'h0002_49f1, 1'b1);
		wr(iqclk_pkg::OFF_CLK_RATE, 32'h0002_49f0, 1'b0);
		rd(iqclk_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0000);
		rd(iqclk_pkg::OFF_SAMPLE_RATE, 32'hffff_ffff, 32'h0001_24f8);
		rd(iqclk_pkg::OFF_LIMITS_MIN, 32'hffff_ffff, 32'h0000_0002);
		wr(iqclk_pkg::OFF_CTRL, 32'h0010_0084, 1'b0);
		rd(iqclk_pkg::OFF_SAMPLE_RATE, 32'hffff_ffff, 32'h0000_927c);
		rd(iqclk_pkg::OFF_LIMITS_MAX, 32'hffff_ffff, 32'h0006_1a80);
		$display("test parallel done");
	endtask : t_parallel
	task automatic t_serial();
		wr(iqclk_pkg::OFF_CTRL, 32'h0010_0001, 1'b0);
		rd(iqclk_pkg::OFF_SAMPLE_RATE, 32'hffff_ffff, 32'h0000_249f);
		rd(iqclk_pkg::OFF_LIMITS_MIN, 32'hffff_ffff, 32'h0000_0010);
		wr(iqclk_pkg::OFF_CLK_RATE, 32'h0000_000f, 1'b1);
		wr(iqclk_pkg::OFF_CLK_RATE, 32'h0002_49f1, 1'b1);
		$display("test serial done");
	endtask : t_serial
	task automatic t_input();
		wr(iqclk_pkg::OFF_CLK_RATE, 32'h0001_86a0, 1'b0);
		wr(iqclk_pkg::OFF_CTRL, 32'h0010_00b0, 1'b0);
		rd(iqclk_pkg::OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
		rd(iqclk_pkg::OFF_SAMPLE_RATE, 32'hffff_ffff, 32'h0001_86a0);
		wr(iqclk_pkg::OFF_CLK_RATE, 32'h0001_86a1, 1'b1);
		wr(iqclk_pkg::OFF_CTRL, 32'h0010_0010, 1'b0);
		wr(iqclk_pkg::OFF_CLK_RATE, 32'h0003_0d40, 1'b0);
		$display("test input done");
	endtask : t_input
	// Level of the source picked by select code s, as the planner sees it
	function automatic logic src_level(input int s);
		case (s)
			0: return int_synth_clk;
			1: return ext_clk_in;
			default: return dut_clk_in;
		endcase
	endfunction : src_level
	// Each source in turn, rate register set to the applied frequency
	task automatic t_route();
		logic [31:0] rate [3] = '{32'h0000_2710, 32'h0000_1388, 32'h0000_186a};
		logic prev;
		for (int s = 0; s < 3; s++) begin
			wr(iqclk_pkg::OFF_CLK_RATE, rate[s], 1'b0);
			wr(iqclk_pkg::OFF_CTRL, 32'h0010_0000 | (32'(s) << 8), 1'b0);
			repeat (4) @(posedge ref_clk);
			prev = src_level(s);
			repeat (40) begin
				@(posedge ref_clk);
				chk("clock out", 32'(clk_out), 32'(prev));
				chk("device clock", 32'(dut_clk_out), 32'(prev));
				prev = src_level(s);
			end
		end
		$display("test route done");
	endtask : t_route
	// Parallel cps 1 then 2 on the internal 10 MHz source, then one 8-bit serial word
	task automatic t_data();
		logic [31:0] held;
		logic [31:0] got;
		logic seen;
		int takes;
		for (int c = 0; c < 2; c++) begin
			wr(iqclk_pkg::OFF_CTRL, 32'h0010_0000 | (32'(c) << 6), 1'b0);
			// Skip the false edge that a source switch may show
			repeat (2) @(posedge ref_clk);
			takes = 0;
			seen = 1'b0;
			held = 32'h0000_0000;
			repeat (100) begin
				@(posedge ref_clk);
				if (sample_take === 1'b1) begin
					takes++;
					seen = 1'b1;
					held = i_word;
					chk("i lines", i_lines, i_word);
					chk("q lines", q_lines, q_word);
				end else if (seen) begin
					chk("i held", i_lines, held);
				end
			end
			chk("sample count", 32'(takes), 32'(10 >> c));
		end
		wr(iqclk_pkg::OFF_CTRL, 32'h0008_0001, 1'b0);
		repeat (2) @(posedge ref_clk);
		while (sample_take !== 1'b1) @(posedge ref_clk);
		held = i_word;
		got = 32'h0000_0000;
		chk("frame pulse", 32'(frame_pulse), 32'h0000_0001);
		for (int k = 0; k < 8; k++) begin
			got[k] = serial_bit;
			if (k == 1) chk("frame low", 32'(frame_pulse), 32'h0000_0000);
			repeat (10) @(posedge ref_clk);
		end
		chk("serial word", got, {24'h00_0000, held[7:0]});
		chk("next frame", 32'(sample_take), 32'h0000_0001);
		$display("test data done");
	endtask : t_data
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_parallel();
		t_serial();
		t_input();
		t_route();
		t_data();
		test_done();
	end
endmodule : iq_interface_clock_rates_tb
